// file: hw/iosw_top.sv
// image output sdram writer: rgb converter, address generator, boxcar
`timescale 1ns/1ps
`default_nettype none
module iosw_top import iosw_pkg::*; #(
    parameter int LINE_W = 16
) (
    // clock and reset
    input  wire logic           clk,
    input  wire logic           rst,
    // register port
    input  wire logic [7:0]     reg_addr,
    input  wire logic [31:0]    reg_wdata,
    input  wire logic           reg_wr,
    input  wire logic           reg_rd,
    output logic [31:0]         reg_rdata,
    // resizer 4:2:2 stream
    input  wire logic           pix_valid,
    input  wire iosw_beat_type  pix_beat,
    output logic                pix_ready,
    // bayer stream for the boxcar
    input  wire logic           bay_valid,
    input  wire iosw_bayer_type bay_pix,
    input  wire logic           hist_busy,
    // sdram write path
    output iosw_mem_type        mem_wr
);
    if (LINE_W < 12 || LINE_W > 16) begin : g_chk
        $error("LINE_W must lie between 12 and 16");
    end

    // ============================================================
    // functions
    function automatic logic is_rsz(input logic [7:0] a);
        return !a[7] && a[5:0] <= OFF_VSZ;
    endfunction : is_rsz

    function automatic logic [7:0] clamp8(input int v);
        if (v < 0) return 8'h00;
        if (v > 255) return 8'hff;
        return v[7:0];
    endfunction : clamp8

    // whole sum divided once by 512: avoids two truncations
    function automatic logic [23:0] to_rgb(input logic [7:0] y,
            input logic [8:0] cb, input logic [8:0] cr);
        int yy;
        int cbp;
        int crp;
        yy  = int'(y);
        cbp = int'(cb) - 128;
        crp = int'(cr) - 128;
        return {clamp8((512 * yy + 718 * crp) >>> 9),
                clamp8((512 * yy - 176 * cbp - 366 * crp) >>> 9),
                clamp8((512 * yy + 907 * cbp) >>> 9)};
    endfunction : to_rgb

    function automatic logic [31:0] fmt(input logic [23:0] c,
            input logic p16, input logic [7:0] alpha);
        if (p16)
            return {16'h0000, c[23:19], c[15:10], c[7:3]};
        return {alpha, c};
    endfunction : fmt

    function automatic logic [15:0] sat16(input logic [21:0] v);
        return (v[21:16] != 6'h00) ? 16'hffff : v[15:0];
    endfunction : sat16

    // ============================================================
    // registers
    logic [4:0]        ctrl_r  [2];
    logic [7:0]        alpha_r [2];
    logic [31:0]       base_r  [2];
    logic [31:0]       sad_r   [2];
    logic [15:0]       oft_r   [2];
    logic [LINE_W-1:0] ptrs_r  [2];
    logic [LINE_W-1:0] ptre_r  [2];
    logic [LINE_W-1:0] ptro_r  [2];
    logic [LINE_W-1:0] vsz_r   [2];
    logic [3:0]        seq_r;
    logic [1:0]        box_r;
    logic [3:0]        shf_r;
    logic [11:0]       boxw_r;
    logic              refused_r;
    logic [31:0]       rdata_r;
    logic              ri;
    logic              hf;
    logic              vf;
    logic              box_refuse;

    assign ri = reg_addr[6];
    // flips only on the fly; hflip never with frame division
    assign hf = seq_r[SEQ_HF] & seq_r[SEQ_OTF] & ~seq_r[SEQ_DIV];
    assign vf = seq_r[SEQ_VF] & seq_r[SEQ_OTF];

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                ctrl_r[i]  <= CTRL_RST;
                alpha_r[i] <= '0;
                base_r[i]  <= '0;
                sad_r[i]   <= '0;
                oft_r[i]   <= '0;
                ptrs_r[i]  <= '0;
                ptre_r[i]  <= '0;
                vsz_r[i]   <= '0;
            end
            seq_r  <= SEQ_RST;
            box_r  <= '0;
            shf_r  <= '0;
            boxw_r <= BOXW_RST;
        end else if (reg_wr && is_rsz(reg_addr)) begin
            unique case (reg_addr[5:0])
                OFF_CTRL:   ctrl_r[ri] <= reg_wdata[4:0];
                OFF_ALPHA:  alpha_r[ri] <= reg_wdata[7:0];
                OFF_BASE_H: base_r[ri][31:16] <= reg_wdata[15:0];
                OFF_BASE_L: base_r[ri][15:0] <= reg_wdata[15:0];
                OFF_SAD_H:  sad_r[ri][31:16] <= reg_wdata[15:0];
                OFF_SAD_L:  sad_r[ri][15:0] <= reg_wdata[15:0];
                OFF_OFT:    oft_r[ri] <= reg_wdata[15:0];
                OFF_PTR_S:  ptrs_r[ri] <= reg_wdata[LINE_W-1:0];
                OFF_PTR_E:  ptre_r[ri] <= reg_wdata[LINE_W-1:0];
                OFF_VSZ:    vsz_r[ri] <= reg_wdata[LINE_W-1:0];
                default: ;
            endcase
        end else if (reg_wr) begin
            unique case (reg_addr)
                ADR_SEQ:    seq_r <= reg_wdata[3:0];
                ADR_BOX:    box_r <= reg_wdata[1:0];
                ADR_BOXSHF: shf_r <= reg_wdata[3:0];
                ADR_BOXW:   boxw_r <= reg_wdata[11:0];
                default: ;
            endcase
        end
    end

    // refusal flag: a new refusal beats a clear in the same cycle
    always_ff @(posedge clk) begin
        if (rst)
            refused_r <= 1'b0;
        else if (box_refuse)
            refused_r <= 1'b1;
        else if (reg_wr && reg_addr == ADR_STATUS && reg_wdata[ST_REF])
            refused_r <= 1'b0;
    end

    // ============================================================
    // read port: data valid only in the cycle after the strobe
    logic hold_v_r;

    always_ff @(posedge clk) begin
        if (rst || !reg_rd) begin
            rdata_r <= '0;
        end else if (is_rsz(reg_addr)) begin
            unique case (reg_addr[5:0])
                OFF_CTRL:   rdata_r <= {27'h0, ctrl_r[ri]};
                OFF_ALPHA:  rdata_r <= {24'h0, alpha_r[ri]};
                OFF_BASE_H: rdata_r <= {16'h0, base_r[ri][31:16]};
                OFF_BASE_L: rdata_r <= {16'h0, base_r[ri][15:0]};
                OFF_SAD_H:  rdata_r <= {16'h0, sad_r[ri][31:16]};
                OFF_SAD_L:  rdata_r <= {16'h0, sad_r[ri][15:0]};
                OFF_OFT:    rdata_r <= {16'h0, oft_r[ri]};
                OFF_PTR_S:  rdata_r <= 32'(ptrs_r[ri]);
                OFF_PTR_E:  rdata_r <= 32'(ptre_r[ri]);
                OFF_PTR_O:  rdata_r <= 32'(ptro_r[ri]);
                OFF_VSZ:    rdata_r <= 32'(vsz_r[ri]);
                default:    rdata_r <= '0;
            endcase
        end else begin
            unique case (reg_addr)
                ADR_SEQ:    rdata_r <= {28'h0, seq_r};
                ADR_BOX:    rdata_r <= {30'h0, box_r};
                ADR_BOXSHF: rdata_r <= {28'h0, shf_r};
                ADR_BOXW:   rdata_r <= {20'h0, boxw_r};
                ADR_STATUS: rdata_r <= {30'h0, hold_v_r, refused_r};
                default:    rdata_r <= '0;
            endcase
        end
    end
    assign reg_rdata = rdata_r;

    // ============================================================
    // chroma upsampling and conversion
    iosw_beat_type hold_r;
    iosw_conv_type cv_r;
    logic          ready_r;
    logic          in_fire;
    logic          proc;
    logic [8:0]    cb1;
    logic [8:0]    cr1;
    logic [4:0]    hc;
    logic [23:0]   c0;
    logic [23:0]   c1;

    assign in_fire = pix_valid & ready_r;
    // a beat waits for the next one to know its right-hand chroma
    assign proc = hold_v_r & (hold_r.eol | in_fire);
    assign hc   = ctrl_r[hold_r.rsz];
    // last beat of a line mirrors its own chroma
    assign cb1 = (9'(hold_r.cb) + 9'(hold_r.eol ? hold_r.cb : pix_beat.cb))
                 >> 1;
    assign cr1 = (9'(hold_r.cr) + 9'(hold_r.eol ? hold_r.cr : pix_beat.cr))
                 >> 1;
    assign c0  = to_rgb(hold_r.y0, {1'b0, hold_r.cb}, {1'b0, hold_r.cr});
    assign c1  = to_rgb(hold_r.y1, cb1, cr1);

    always_ff @(posedge clk) begin
        if (rst) begin
            ready_r  <= 1'b0;
            hold_v_r <= 1'b0;
            hold_r   <= '0;
        end else begin
            // one idle cycle after each line end flushes the held beat
            ready_r <= ~(in_fire & pix_beat.eol) & ~box_r[BOX_EN];
            if (in_fire) begin
                hold_r   <= pix_beat;
                hold_v_r <= 1'b1;
            end else if (proc) begin
                hold_v_r <= 1'b0;
            end
        end
    end
    assign pix_ready = ready_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            cv_r <= '0;
        end else begin
            cv_r.valid <= proc;
            cv_r.keep  <= ~(hc[CTRL_RGB] & ((hold_r.sol & hc[CTRL_MS0]) |
                          (hold_r.eol & hc[CTRL_MS1])));
            cv_r.sof   <= hold_r.sof;
            cv_r.eol   <= hold_r.eol;
            cv_r.rsz   <= hold_r.rsz;
            cv_r.w16   <= hc[CTRL_RGB] & hc[CTRL_P16];
            cv_r.hf    <= hf;
            if (hc[CTRL_RGB]) begin
                cv_r.units <= 2'd2;
                cv_r.p0 <= fmt(c0, hc[CTRL_P16], alpha_r[hold_r.rsz]);
                cv_r.p1 <= fmt(c1, hc[CTRL_P16], alpha_r[hold_r.rsz]);
            end else begin
                // plain 4:2:2 word, luma pair swapped under hflip
                cv_r.units <= 2'd1;
                cv_r.p0 <= hf ? {hold_r.y0, hold_r.cr, hold_r.y1, hold_r.cb}
                              : {hold_r.y1, hold_r.cr, hold_r.y0, hold_r.cb};
                cv_r.p1 <= '0;
            end
        end
    end

    // ============================================================
    // burst packer and sdram address generator
    logic [255:0]      burst_r;
    logic [31:0]       be_r;
    logic [4:0]        cnt_r;
    logic [31:0]       laddr_r [2];
    logic [31:0]       col_r   [2];
    logic [LINE_W-1:0] ptr_r   [2];
    logic [LINE_W-1:0] lines_r [2];
    logic [255:0]      bnxt;
    logic [31:0]       benxt;
    logic [4:0]        cnt_sum;
    logic [4:0]        cap;
    logic              cr_i;
    logic              ring;
    logic              act;
    logic              emit;
    logic [31:0]       ccol;
    logic [31:0]       cla;
    logic [LINE_W-1:0] cptr;
    logic [LINE_W-1:0] clines;

    assign cr_i   = cv_r.rsz;
    assign ring   = ctrl_r[cr_i][CTRL_RNG];
    assign cap    = cv_r.w16 ? CAP16 : CAP32;
    assign ccol   = cv_r.sof ? sad_r[cr_i] : col_r[cr_i];
    assign cla    = cv_r.sof ? sad_r[cr_i] : laddr_r[cr_i];
    assign cptr   = cv_r.sof ? ptrs_r[cr_i] : ptr_r[cr_i];
    assign clines = cv_r.sof ? '0 : lines_r[cr_i];
    // linear frames end after the programmed number of lines
    assign act    = ring | (clines < vsz_r[cr_i]);

    always_comb begin
        logic [4:0] pos;
        logic [4:0] slot;
        pos   = '0;
        slot  = '0;
        bnxt  = burst_r;
        benxt = be_r;
        cnt_sum = cnt_r;
        if (cv_r.valid && cv_r.keep && act) begin
            for (int k = 0; k < 2; k++) begin
                if (k < int'(cv_r.units)) begin
                    pos  = cnt_r + 5'(k);
                    slot = cv_r.hf ? cap - 5'd1 - pos : pos;
                    if (cv_r.w16) begin
                        bnxt[slot*16 +: 16] = k == 0 ? cv_r.p0[15:0]
                                                     : cv_r.p1[15:0];
                        benxt[slot*2 +: 2] = 2'b11;
                    end else begin
                        bnxt[slot*32 +: 32] = k == 0 ? cv_r.p0 : cv_r.p1;
                        benxt[slot*4 +: 4] = 4'hf;
                    end
                end
            end
            cnt_sum = cnt_r + 5'(cv_r.units);
        end
        emit = cv_r.valid && (cnt_sum == cap ||
               (cv_r.eol && cnt_sum != 5'd0));
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            burst_r <= '0;
            be_r    <= '0;
            cnt_r   <= '0;
        end else if (emit) begin
            burst_r <= '0;
            be_r    <= '0;
            cnt_r   <= '0;
        end else begin
            burst_r <= bnxt;
            be_r    <= benxt;
            cnt_r   <= cnt_sum;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < 2; i++) begin
                laddr_r[i] <= '0;
                col_r[i]   <= '0;
                ptr_r[i]   <= '0;
                lines_r[i] <= '0;
                ptro_r[i]  <= '0;
            end
        end else if (cv_r.valid && cv_r.eol) begin
            ptro_r[cr_i]  <= cptr;
            lines_r[cr_i] <= clines + 1'b1;
            if (ring && cptr + 1'b1 >= ptre_r[cr_i]) begin
                ptr_r[cr_i]   <= '0;
                laddr_r[cr_i] <= base_r[cr_i];
                col_r[cr_i]   <= base_r[cr_i];
            end else begin
                ptr_r[cr_i]   <= cptr + 1'b1;
                laddr_r[cr_i] <= vf ? cla - {16'h0, oft_r[cr_i]}
                                    : cla + {16'h0, oft_r[cr_i]};
                col_r[cr_i]   <= vf ? cla - {16'h0, oft_r[cr_i]}
                                    : cla + {16'h0, oft_r[cr_i]};
            end
        end else if (cv_r.valid) begin
            laddr_r[cr_i] <= cla;
            ptr_r[cr_i]   <= cptr;
            lines_r[cr_i] <= clines;
            if (emit)
                col_r[cr_i] <= cv_r.hf ? ccol - BURST_B : ccol + BURST_B;
            else
                col_r[cr_i] <= ccol;
        end
    end

    // ============================================================
    // boxcar averager
    logic [65:0] box_mem [256];
    logic [11:0] bx_r;
    logic [11:0] by_r;
    logic [31:0] baddr_r;
    logic        b_fire;
    logic        b16;
    logic [11:0] cx;
    logic [11:0] cy;
    logic [7:0]  bidx;
    logic        bfirst;
    logic        blast;
    logic [65:0] bsum;
    logic [31:0] bcur;
    logic [47:0] bres;

    assign b16    = box_r[BOX_B16];
    assign b_fire = bay_valid & box_r[BOX_EN] & ~hist_busy;
    assign box_refuse = bay_valid & box_r[BOX_EN] & hist_busy;
    assign cx     = bay_pix.sof ? '0 : bx_r;
    assign cy     = bay_pix.sof ? '0 : by_r;
    assign bidx   = b16 ? cx[11:4] : cx[10:3];
    assign bfirst = b16 ? (cx[3:0] == 4'h0 && cy[3:0] == 4'h0)
                        : (cx[2:0] == 3'h0 && cy[2:0] == 3'h0);
    assign blast  = b16 ? (cx[3:0] == 4'hf && cy[3:0] == 4'hf)
                        : (cx[2:0] == 3'h7 && cy[2:0] == 3'h7);
    assign bcur   = bay_pix.sof ? sad_r[0] : baddr_r;

    always_comb begin
        bsum = bfirst ? '0 : box_mem[bidx];
        unique case ({cy[0], cx[0]})
            2'b00:   bsum[21:0]  = bsum[21:0] + 22'(bay_pix.raw);
            2'b11:   bsum[65:44] = bsum[65:44] + 22'(bay_pix.raw);
            default: bsum[43:22] = bsum[43:22] + 22'(bay_pix.raw);
        endcase
        // green has twice the samples, so its sum is halved
        bres = {sat16(bsum[65:44] >> shf_r),
                sat16((bsum[43:22] >> 1) >> shf_r),
                sat16(bsum[21:0] >> shf_r)};
    end

    always_ff @(posedge clk) begin
        if (b_fire)
            box_mem[bidx] <= bsum;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            bx_r    <= '0;
            by_r    <= '0;
            baddr_r <= '0;
        end else if (b_fire) begin
            bx_r <= (cx == boxw_r - 1'b1) ? '0 : cx + 1'b1;
            by_r <= (cx == boxw_r - 1'b1) ? cy + 1'b1 : cy;
            // results run on with no gap between block rows
            baddr_r <= blast ? bcur + SLOT_B : bcur;
        end
    end

    // ============================================================
    // shared sdram write port; the two sources never run together
    iosw_mem_type mem_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            mem_r <= '0;
        end else if (b_fire && blast) begin
            mem_r.valid <= 1'b1;
            mem_r.addr  <= bcur;
            mem_r.data  <= 256'({16'h0000, bres}) << {bcur[4:3], 6'h00};
            mem_r.be    <= 32'h0000_00ff << {bcur[4:3], 3'h0};
        end else if (emit) begin
            mem_r.valid <= 1'b1;
            mem_r.addr  <= ccol;
            mem_r.data  <= bnxt;
            mem_r.be    <= benxt;
        end else begin
            mem_r.valid <= 1'b0;
        end
    end
    assign mem_wr = mem_r;
endmodule : iosw_top
`default_nettype wire

// file: hw/iosw_pkg.sv
// constants, register map and carriers for the image output sdram writer
// ============================================================
package iosw_pkg;
    // ============================================================
    // register map: addr[7]=0 per resizer, addr[6] picks the resizer
    localparam logic [5:0] OFF_CTRL   = 6'h00;
    localparam logic [5:0] OFF_ALPHA  = 6'h04;
    localparam logic [5:0] OFF_BASE_H = 6'h08;
    localparam logic [5:0] OFF_BASE_L = 6'h0c;
    localparam logic [5:0] OFF_SAD_H  = 6'h10;
    localparam logic [5:0] OFF_SAD_L  = 6'h14;
    localparam logic [5:0] OFF_OFT    = 6'h18;
    localparam logic [5:0] OFF_PTR_S  = 6'h1c;
    localparam logic [5:0] OFF_PTR_E  = 6'h20;
    localparam logic [5:0] OFF_PTR_O  = 6'h24;
    localparam logic [5:0] OFF_VSZ    = 6'h28;
    localparam logic [7:0] ADR_SEQ    = 8'h80;
    localparam logic [7:0] ADR_BOX    = 8'h84;
    localparam logic [7:0] ADR_BOXSHF = 8'h88;
    localparam logic [7:0] ADR_BOXW   = 8'h8c;
    localparam logic [7:0] ADR_STATUS = 8'h90;
    // ============================================================
    // field positions
    localparam int CTRL_RGB = 0;
    localparam int CTRL_P16 = 1;
    localparam int CTRL_MS0 = 2;
    localparam int CTRL_MS1 = 3;
    localparam int CTRL_RNG = 4;
    localparam int SEQ_HF   = 0;
    localparam int SEQ_VF   = 1;
    localparam int SEQ_OTF  = 2;
    localparam int SEQ_DIV  = 3;
    localparam int BOX_EN   = 0;
    localparam int BOX_B16  = 1;
    localparam int ST_REF   = 0;
    localparam int ST_BUSY  = 1;
    // ============================================================
    // reset values and fixed figures
    localparam logic [4:0]  CTRL_RST  = 5'h00;
    localparam logic [3:0]  SEQ_RST   = 4'h4;
    localparam logic [11:0] BOXW_RST  = 12'h000;
    localparam logic [31:0] BURST_B   = 32'h0000_0020;
    localparam logic [31:0] SLOT_B    = 32'h0000_0008;
    localparam logic [4:0]  CAP32     = 5'h08;
    localparam logic [4:0]  CAP16     = 5'h10;
    // ============================================================
    // carriers
    typedef struct packed {
        logic       sof;
        logic       sol;
        logic       eol;
        logic       rsz;
        logic [7:0] y1;
        logic [7:0] cr;
        logic [7:0] y0;
        logic [7:0] cb;
    } iosw_beat_type;
    typedef struct packed {
        logic        sof;
        logic [13:0] raw;
    } iosw_bayer_type;
    typedef struct packed {
        logic         valid;
        logic [31:0]  addr;
        logic [255:0] data;
        logic [31:0]  be;
    } iosw_mem_type;
    typedef struct packed {
        logic        valid;
        logic        keep;
        logic        sof;
        logic        eol;
        logic        rsz;
        logic        w16;
        logic        hf;
        logic [1:0]  units;
        logic [31:0] p0;
        logic [31:0] p1;
    } iosw_conv_type;
endpackage : iosw_pkg

// file: tb/iosw_props.sv
// assertions on the ports of the image output sdram writer
`timescale 1ns/1ps
`default_nettype none
module iosw_props import iosw_pkg::*; (
    // clock and reset
    input wire logic          clk,
    input wire logic          rst,
    // register port
    input wire logic [7:0]    reg_addr,
    input wire logic [31:0]   reg_wdata,
    input wire logic          reg_wr,
    input wire logic          reg_rd,
    input wire logic [31:0]   reg_rdata,
    // streams
    input wire logic          pix_valid,
    input wire iosw_beat_type pix_beat,
    input wire logic          pix_ready,
    input wire iosw_mem_type  mem_wr
);
    // ====
    // helper state
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    logic box_on_r;
    always_ff @(posedge clk) begin
        if (rst) box_on_r <= 1'b0;
        else if (reg_wr && reg_addr == ADR_BOX) box_on_r <= reg_wdata[BOX_EN];
    end
    sequence s_eol_take;
        pix_valid && pix_ready && pix_beat.eol;
    endsequence
    sequence s_gap;
        !pix_ready ##1 pix_ready;
    endsequence
    // ====
    // properties
    a_reset_quiet: assert property (
        $fell(rst) |-> reg_rdata == 32'h0 && !mem_wr.valid && !pix_ready)
        else $error("outputs active after reset");
    a_read_idle: assert property (
        !$past(reg_rd) |-> reg_rdata == 32'h0) else $error("stray read data");
    a_read_unmapped: assert property (
        reg_rd && reg_addr > ADR_STATUS |=> reg_rdata == 32'h0)
        else $error("unmapped read not zero");
    a_eol_gap: assert property (s_eol_take |=> s_gap)
        else $error("ready gap after line end wrong");
    a_eol_flush: assert property (s_eol_take |-> ##[1:4] mem_wr.valid)
        else $error("line end not flushed");
    a_burst_single: assert property (
        mem_wr.valid |=> !mem_wr.valid) else $error("burst pulse too long");
    a_slot_align: assert property (
        mem_wr.valid |-> mem_wr.addr[2:0] == 3'h0) else $error("misaligned write");
    a_box_holds: assert property (
        box_on_r && $past(box_on_r) |-> !pix_ready)
        else $error("pipe open while boxcar runs");
endmodule : iosw_props
bind iosw_top iosw_props i_iosw_props (.clk, .rst, .reg_addr, .reg_wdata,
    .reg_wr, .reg_rd, .reg_rdata, .pix_valid, .pix_beat, .pix_ready, .mem_wr);
`default_nettype wire

// file: tb/iosw_sdram_model.sv
// sdram write sink that records the bursts handed to it
`timescale 1ns/1ps
`default_nettype none
module iosw_sdram_model import iosw_pkg::*; (
    // clock and reset
    input wire logic         clk,
    input wire logic         rst,
    // write path
    input wire iosw_mem_type mem_wr
);
    // ====
    // no back-pressure, so every pulse is a whole burst
    iosw_mem_type last_r;
    int           count_r;
    always_ff @(posedge clk) begin
        if (rst) begin
            count_r <= 0;
        end else if (mem_wr.valid) begin
            last_r  <= mem_wr;
            count_r <= count_r + 1;
        end
    end
endmodule : iosw_sdram_model
`default_nettype wire

// file: tb/iosw_top_test.sv
// self-checking bench for the image output sdram writer
`timescale 1ns/1ps
`default_nettype none
module iosw_top_test import iosw_pkg::*; ;
    logic           clk, rst, reg_wr, reg_rd, pix_valid, pix_ready;
    logic           bay_valid, hist_busy;
    logic [7:0]     reg_addr;
    logic [31:0]    reg_wdata, reg_rdata, rd_val;
    iosw_beat_type  pix_beat;
    iosw_bayer_type bay_pix;
    iosw_mem_type   mem_wr, got;
    int             err_count, check_count;
    iosw_top i_iosw_top (.clk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .pix_valid, .pix_beat, .pix_ready, .bay_valid, .bay_pix,
        .hist_busy, .mem_wr);
    iosw_sdram_model i_iosw_sdram_model (.clk, .rst, .mem_wr);
    assign got = i_iosw_sdram_model.last_r;
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // ====
    // shared tasks
    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        check_count++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        rd_val = reg_rdata;
    endtask : rd
    // one line of n beats, y 0x64 with cr 0xb2 and neutral cb
    task automatic line(input int n, input logic sof);
        @(posedge clk);
        for (int i = 0; i < n; i++) begin
            pix_valid <= 1'b1;
            pix_beat  <= {sof && i == 0, i == 0, i == n - 1, 1'b0, 8'h64,
                          8'hb2, 8'h64, 8'h80};
            @(posedge clk);
            while (!pix_ready) @(posedge clk);
        end
        pix_valid <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : line
    // ====
    // scenarios
    task automatic t_regs;
        rd(ADR_SEQ);
        check(rd_val, {28'h0, SEQ_RST});
        rd({2'b00, OFF_CTRL});
        check(rd_val, {27'h0, CTRL_RST});
        rd(8'hfc);
        check(rd_val, 32'h0);
    endtask : t_regs
    task automatic t_rgb32;
        wr({2'b00, OFF_CTRL}, 32'h1);
        wr({2'b00, OFF_ALPHA}, 32'h5a);
        wr({2'b00, OFF_SAD_H}, 32'h0);
        wr({2'b00, OFF_SAD_L}, 32'h1000);
        wr({2'b00, OFF_OFT}, 32'h100);
        wr({2'b00, OFF_VSZ}, 32'h4);
        line(2, 1'b1);
        check(got.addr, 32'h1000);
        check(got.data[63:0], {2{32'h5aaa4064}});
        check(got.data[127:64], {2{32'h5aaa4064}});
        check(got.be, 32'h0000ffff);
        // hflip: start address is the right-hand end, slots fill downwards
        wr(ADR_SEQ, 32'h5);
        line(2, 1'b1);
        check(got.addr, 32'h1000);
        check(got.data[255:192], {2{32'h5aaa4064}});
        check(got.be, 32'hffff0000);
        // frame division blocks hflip, vflip still steps lines down
        wr(ADR_SEQ, 32'hf);
        line(2, 1'b1);
        line(2, 1'b0);
        check(got.addr, 32'h0f00);
        check(got.be, 32'h0000ffff);
        wr(ADR_SEQ, 32'h4);
    endtask : t_rgb32
    task automatic t_ring;
        wr({2'b00, OFF_CTRL}, 32'h1f);
        wr({2'b00, OFF_BASE_H}, 32'h0);
        wr({2'b00, OFF_BASE_L}, 32'h2000);
        wr({2'b00, OFF_PTR_S}, 32'h0);
        wr({2'b00, OFF_PTR_E}, 32'h2);
        line(4, 1'b1);
        check(got.addr, 32'h1000);
        check(got.data[63:0], {4{16'haa0c}});
        check(got.be, 32'h000000ff);
        line(4, 1'b0);
        check(got.addr, 32'h1100);
        line(4, 1'b0);
        check(got.addr, 32'h2000);
        rd({2'b00, OFF_PTR_O});
        check(rd_val, 32'h0);
    endtask : t_ring
    task automatic t_box;
        wr(ADR_BOX, 32'h1);
        wr(ADR_BOXSHF, 32'h2);
        wr(ADR_BOXW, 32'h8);
        @(posedge clk);
        bay_valid <= 1'b1;
        hist_busy <= 1'b1;
        @(posedge clk);
        bay_valid <= 1'b0;
        hist_busy <= 1'b0;
        rd(ADR_STATUS);
        check(rd_val[0], 1'b1);
        wr(ADR_STATUS, 32'h1);
        rd(ADR_STATUS);
        check(rd_val[0], 1'b0);
        @(posedge clk);
        for (int r = 0; r < 8; r++) begin
            for (int c = 0; c < 8; c++) begin
                bay_valid <= 1'b1;
                bay_pix   <= {r == 0 && c == 0, (r[0] & c[0]) ? 14'h300 :
                              (r[0] | c[0]) ? 14'h200 : 14'h100};
                @(posedge clk);
            end
        end
        bay_valid <= 1'b0;
        repeat (3) @(posedge clk);
        check(got.addr, 32'h1000);
        check(got.data[63:0], 64'h0000_0c00_0800_0400);
        check(got.be, 32'h000000ff);
        // eight bursts in the whole run, none for the refused pixel
        check(i_iosw_sdram_model.count_r, 64'h8);
        wr(ADR_BOX, 32'h0);
    endtask : t_box
    task automatic end_of_test;
        if (err_count == 0 && check_count > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    // ====
    // main sequence and watchdog
    initial begin
        rst = 1'b1;
        {reg_wr, reg_rd, pix_valid, bay_valid, hist_busy} = 5'h00;
        reg_addr  = 8'h00;
        reg_wdata = 32'h0;
        pix_beat  = '0;
        bay_pix   = '0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        t_regs;
        t_rgb32;
        t_ring;
        t_box;
        end_of_test;
    end
    initial begin
        repeat (5000) @(posedge clk);
        err_count++;
        end_of_test;
    end
endmodule : iosw_top_test
`default_nettype wire
